// *** hdl/led_select_and_init_status.sv ***
// led colour select, auto-init status on the host interrupt pin,
// control port target and successive-approximation temperature conversion
// assumes rst is the chip reset already brought onto clk; pull-ups are external
`timescale 1ns/1ps
`include "led_ctrl_params.svh"

// Functional notes
// - led select follows sequence, 00 none, 01/10/11 rgb
// - led select low while chip reset held
// - led select low until auto-init finishes
// - host interrupt shows init busy, then completion
// - host interrupt undriven during reset
// - control port is an i2c target
// - sar conversion using charge output and comparator
module led_select_and_init_status
  import led_ctrl_pkg::*;
#(
  parameter int         INIT_CYCLES = `INIT_CYCLES_DEF,
  parameter int         SAR_BITS    = 8,
  parameter logic [3:0] SETTLE      = `SETTLE_DEF,
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEF  // arbitrary address value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // led driver
  output logic [1:0]      led_colour_select,
  // host interrupt, tri-state
  output od_pin_t         host_irq,
  // control port open-drain pins
  input  wire logic       control_port_clock_in,
  output od_pin_t         control_port_clock,
  input  wire logic       control_port_data_in,
  output od_pin_t         control_port_data,
  // temperature conversion
  input  wire logic       comparator_result_in,
  output logic            ramp_charge_out
);

  logic [2:0]          pin_sync;
  logic                cmp_s;
  logic                scl_s;
  logic                sda_s;
  logic                scl_q;
  logic                sda_q;
  logic [15:0]         init_cnt;
  logic                init_done;
  logic [7:0]          ctrl;
  logic [7:0]          dur [1:3];
  logic [7:0]          temp;
  logic                sar_busy;
  i2c_state_t          i2c_st;
  logic [3:0]          bit_cnt;
  logic [7:0]          rx;
  logic [7:0]          tx;
  logic                rw;
  logic                have_ptr;
  logic [2:0]          ptr;
  logic [7:0]          rd_data;
  logic [1:0]          colour;
  logic [15:0]         seg_cnt;
  sar_state_t          sar_st;
  logic [SAR_BITS-1:0] trial;
  logic [SAR_BITS-1:0] sar_mask;
  logic [SAR_BITS-1:0] pwm_cnt;
  logic [3:0]          periods;

  // comparator and both bus pins pass two flops before use
  sync_2ff #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({comparator_result_in, control_port_clock_in, control_port_data_in}),
    .sync_out (pin_sync)
  );
  assign cmp_s = pin_sync[2];
  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  // auto-init timer; led sequence and conversion wait until it expires, the i2c target does not
  always_ff @(posedge clk) begin
    if (rst) begin
      init_cnt  <= 16'h0000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt  <= init_cnt + 16'h0001;
      init_done <= (init_cnt == 16'(INIT_CYCLES - 1));
    end
  end

  // host interrupt: released in reset, high while busy, low once done
  always_ff @(posedge clk) begin
    if (rst) begin
      host_irq <= '{out: 1'b0, oe: 1'b0};
    end else begin
      host_irq <= '{out: !init_done, oe: 1'b1};
    end
  end

  // clock pin is never stretched; register keeps the output flop-driven
  always_ff @(posedge clk) begin
    control_port_clock <= '{out: 1'b0, oe: 1'b0};
  end

  // edge history of the synchronised bus pins
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // read mux of the control registers
  always_comb begin
    rd_data = 8'h00;
    case (ptr)
      `REG_CTRL:      rd_data = ctrl;
      `REG_DUR_RED:   rd_data = dur[1];
      `REG_DUR_GREEN: rd_data = dur[2];
      `REG_DUR_BLUE:  rd_data = dur[3];
      `REG_TEMP:      rd_data = temp;
      `REG_STATUS: begin
        rd_data[`STAT_DONE_BIT] = init_done;
        rd_data[`STAT_BUSY_BIT] = sar_busy;
      end
      default:        rd_data = 8'h00;
    endcase
  end

  // i2c target: start/stop win over bit handling, data driven on scl fall
  always_ff @(posedge clk) begin
    if (rst) begin
      i2c_st            <= I2C_IDLE;
      bit_cnt           <= 4'h0;
      rx                <= 8'h00;
      tx                <= 8'h00;
      rw                <= 1'b0;
      have_ptr          <= 1'b0;
      ptr               <= 3'h0;
      ctrl              <= `CTRL_RESET;
      dur[1]            <= `DUR_RESET;
      dur[2]            <= `DUR_RESET;
      dur[3]            <= `DUR_RESET;
      control_port_data <= '{out: 1'b0, oe: 1'b0};
    end else if (scl_s && scl_q && sda_q && !sda_s) begin
      i2c_st               <= I2C_ADDR;
      bit_cnt              <= 4'h0;
      control_port_data.oe <= 1'b0;
    end else if (scl_s && scl_q && !sda_q && sda_s) begin
      i2c_st               <= I2C_IDLE;
      control_port_data.oe <= 1'b0;
    end else if (scl_s && !scl_q) begin
      // rising clock: sample
      case (i2c_st)
        I2C_ADDR, I2C_WR: begin
          rx      <= {rx[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        I2C_RD:     bit_cnt <= bit_cnt + 4'h1;
        I2C_RD_ACK: if (sda_s) i2c_st <= I2C_IDLE;  // nack ends the read
        default:    ;
      endcase
    end else if (!scl_s && scl_q) begin
      // falling clock: drive
      case (i2c_st)
        I2C_ADDR: if (bit_cnt == `BYTE_BITS) begin
          if (rx[7:1] == TARGET_ADDR) begin
            i2c_st               <= I2C_ADDR_ACK;
            rw                   <= rx[0];
            control_port_data.oe <= 1'b1;
          end else begin
            i2c_st <= I2C_IDLE;
          end
        end
        I2C_ADDR_ACK, I2C_RD_ACK: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            i2c_st               <= I2C_RD;
            control_port_data.oe <= !rd_data[7];
            tx                   <= {rd_data[6:0], 1'b0};
            ptr                  <= ptr + 3'h1;
          end else begin
            i2c_st               <= I2C_WR;
            have_ptr             <= 1'b0;
            control_port_data.oe <= 1'b0;
          end
        end
        I2C_WR: if (bit_cnt == `BYTE_BITS) begin
          i2c_st               <= I2C_WR_ACK;
          control_port_data.oe <= 1'b1;
          have_ptr             <= 1'b1;
          if (!have_ptr) begin
            ptr <= rx[2:0];
          end else begin
            ptr <= ptr + 3'h1;
            if (ptr == `REG_CTRL) ctrl <= rx;
            if (ptr >= `REG_DUR_RED && ptr <= `REG_DUR_BLUE) dur[ptr[1:0]] <= rx;
          end
        end
        I2C_WR_ACK: begin
          i2c_st               <= I2C_WR;
          bit_cnt              <= 4'h0;
          control_port_data.oe <= 1'b0;
        end
        I2C_RD: if (bit_cnt == `BYTE_BITS) begin
          i2c_st               <= I2C_RD_ACK;
          control_port_data.oe <= 1'b0;
        end else begin
          control_port_data.oe <= !tx[7];
          tx                   <= {tx[6:0], 1'b0};
        end
        default: ;
      endcase
    end
  end

  // colour sequence: red, green, blue, each held dur<<8 cycles
  // a zero duration skips its colour after one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      colour            <= `LED_RED;
      seg_cnt           <= 16'h0000;
      led_colour_select <= `LED_NONE;
    end else if (!init_done || !ctrl[`CTRL_SEQ_EN_BIT]) begin
      colour            <= `LED_RED;
      seg_cnt           <= {dur[1], 8'h00};
      led_colour_select <= `LED_NONE;
    end else begin
      led_colour_select <= colour;
      if (seg_cnt <= 16'h0001) begin
        colour  <= (colour == `LED_BLUE) ? `LED_RED : colour + 2'h1;
        seg_cnt <= {dur[(colour == `LED_BLUE) ? 1 : colour + 2'h1], 8'h00};
      end else begin
        seg_cnt <= seg_cnt - 16'h0001;
      end
    end
  end

  // charge output is a pwm of the trial code; slow but needs no dac
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_cnt         <= '0;
      ramp_charge_out <= 1'b0;
    end else begin
      pwm_cnt         <= pwm_cnt + 1'b1;
      ramp_charge_out <= sar_busy && (pwm_cnt < trial);
    end
  end

  // binary search, msb first, restarting after each result
  always_ff @(posedge clk) begin
    if (rst) begin
      sar_st   <= SAR_IDLE;
      sar_busy <= 1'b0;
      trial    <= '0;
      sar_mask <= '0;
      periods  <= 4'h0;
      temp     <= 8'h00;
    end else begin
      case (sar_st)
        SAR_IDLE: if (init_done) begin
          sar_st   <= SAR_TRIAL;
          sar_busy <= 1'b1;
          sar_mask <= {1'b1, {(SAR_BITS-1){1'b0}}};
          trial    <= {1'b1, {(SAR_BITS-1){1'b0}}};
          periods  <= 4'h0;
        end
        SAR_TRIAL: if (pwm_cnt == '1) begin
          if (periods == SETTLE - 4'h1) begin
            // comparator high means the ramp is still below the thermistor
            periods  <= 4'h0;
            sar_mask <= sar_mask >> 1;
            trial    <= (cmp_s ? trial : (trial & ~sar_mask)) | (sar_mask >> 1);
            if (sar_mask[0]) sar_st <= SAR_DONE;
          end else begin
            periods <= periods + 4'h1;
          end
        end
        SAR_DONE: begin
          temp     <= 8'(trial);
          sar_busy <= 1'b0;
          sar_st   <= SAR_IDLE;
        end
        default: sar_st <= SAR_IDLE;
      endcase
    end
  end

endmodule : led_select_and_init_status

// *** pkg/led_ctrl_params.svh ***
// named constants for the led select / init status block
// assumes inclusion by bare name from the package and design files
`ifndef LED_CTRL_PARAMS_SVH
`define LED_CTRL_PARAMS_SVH

// led colour select codes
`define LED_NONE        2'h0
`define LED_RED         2'h1
`define LED_GREEN       2'h2
`define LED_BLUE        2'h3

// control port register indices
`define REG_CTRL        3'h0
`define REG_DUR_RED     3'h1
`define REG_DUR_GREEN   3'h2
`define REG_DUR_BLUE    3'h3
`define REG_TEMP        3'h4
`define REG_STATUS      3'h5

// field positions and reset values
`define CTRL_SEQ_EN_BIT 0
`define STAT_DONE_BIT   0
`define STAT_BUSY_BIT   1
`define CTRL_RESET      8'h00
`define DUR_RESET       8'h10

// timing and bus defaults
`define INIT_CYCLES_DEF 16'h0400
`define SETTLE_DEF      4'h4
`define TARGET_ADDR_DEF 7'h2A
`define BYTE_BITS       4'h8
`define DUR_SHIFT       8

`endif

// *** pkg/led_ctrl_pkg.sv ***
// types shared by the led select / init status design
// assumes the params header sits on the include path
`include "led_ctrl_params.svh"

package led_ctrl_pkg;

  // one open-drain or tri-state pin as driven by the design
  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_t;

  // control port target states
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_WR,
    I2C_WR_ACK,
    I2C_RD,
    I2C_RD_ACK
  } i2c_state_t;

  // conversion states
  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_TRIAL,
    SAR_DONE
  } sar_state_t;

endpackage : led_ctrl_pkg

// *** hdl/sync_2ff.sv ***
// two-flop synchroniser, one bit lane per input
// assumes inputs are asynchronous to clk; only the second stage is read outside
`timescale 1ns/1ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync_2ff

// *** verification/led_status_props.sv ***
// checker for the led select, host interrupt and control port data pin
// assumes binding onto led_select_and_init_status with sync active-high rst
`timescale 1ns/1ps
module led_status_checker
  import led_ctrl_pkg::*;
#(
  parameter int INIT_CYCLES = 16
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // watched outputs
  input wire logic [1:0] led_colour_select,
  input wire od_pin_t    host_irq,
  input wire od_pin_t    control_port_data
);
  default clocking cb @(posedge clk); endclocking
  int unsigned init_cnt;
  // cycles the interrupt pin reports init busy; gives the init length a figure
  always_ff @(posedge clk) begin
    if (rst)
      init_cnt <= 0;
    else if (host_irq.oe && host_irq.out)
      init_cnt <= init_cnt + 1;
  end
  sequence busy_s;
    host_irq.oe && host_irq.out;
  endsequence
  sequence done_s;
    host_irq.oe && !host_irq.out;
  endsequence
  chk_led_reset_off: assert property (rst |=> led_colour_select == 2'h0)
    else $error("led select not off in reset");
  chk_irq_reset_float: assert property (rst |=> !host_irq.oe)
    else $error("host irq driven in reset");
  chk_irq_busy_start: assert property (disable iff (rst) $fell(rst) |=> busy_s [*8])
    else $error("host irq not busy after reset");
  chk_init_length: assert property (disable iff (rst) $fell(host_irq.out) && host_irq.oe |->
    init_cnt >= INIT_CYCLES - 1 && init_cnt <= INIT_CYCLES + 2)
    else $error("init length wrong");
  chk_irq_done_holds: assert property (disable iff (rst) done_s |=> done_s)
    else $error("host irq left done state");
  chk_led_init_off: assert property (disable iff (rst) busy_s |-> led_colour_select == 2'h0)
    else $error("led lit during init");
  chk_led_order: assert property (disable iff (rst) $changed(led_colour_select) &&
    led_colour_select != 2'h0 |-> done_s and led_colour_select ==
    (($past(led_colour_select) == 2'h3) ? 2'h1 : $past(led_colour_select) + 2'h1))
    else $error("led colour order wrong");
  chk_sda_open_drain: assert property (disable iff (rst) control_port_data.oe |-> !control_port_data.out)
    else $error("data pin driven high");
endmodule : led_status_checker

bind led_select_and_init_status led_status_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .led_colour_select(led_colour_select), .host_irq(host_irq),
  .control_port_data(control_port_data));

// *** verification/i2c_host_model.sv ***
// behavioural i2c controller standing in for the host on the control port
// assumes open-drain pins with pull-ups; bit phases are paced by the core clock
`timescale 1ns/1ps
module i2c_host_model
  import led_ctrl_pkg::*;
(
  // pacing clock
  input  wire logic    clk,
  // device pin drives
  input  wire od_pin_t dev_scl,
  input  wire od_pin_t dev_sda,
  // resolved wire levels
  output logic         scl,
  output logic         sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // wired-and with pull-up: high unless a party pulls low
  assign scl = ~(scl_low | (dev_scl.oe & ~dev_scl.out));
  assign sda = ~(sda_low | (dev_sda.oe & ~dev_sda.out));

  task automatic half();
    repeat (8) @(negedge clk);
  endtask : half
  // data falls while clock high
  task automatic start();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask : start
  // data rises while clock high, bus left idle
  task automatic stop();
    half();
    sda_low = 1'b1;
    half();
    scl_low = 1'b0;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // byte msb first then ack slot; data moves only while clock low
  task automatic xfer(input logic [7:0] tx, input logic ack_low, output logic [7:0] rx, output logic ack);
    logic [8:0] lows;
    logic [8:0] seen;
    lows = {~tx, ack_low};
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      sda_low = lows[i];
      half();
      scl_low = 1'b0;
      half();
      seen[i] = sda;
      scl_low = 1'b1;
    end
    rx = seen[8:1];
    ack = seen[0];
  endtask : xfer
endmodule : i2c_host_model

// *** verification/tb_top.sv ***
// self-checking bench for led select and init status
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module tb_top
  import led_ctrl_pkg::*;
;
  localparam int         INIT = 16;
  localparam logic [6:0] ADDR = 7'h2A;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmp_in = 1'b1;
  logic [1:0] led;
  logic       ramp, scl, sda;
  od_pin_t    irq, scl_pin, sda_pin;
  int         miscompares = 0;
  int         samples_checked = 0;

  // 50 ns core clock
  initial begin
    forever #25 clk = ~clk;
  end

  led_select_and_init_status #(.INIT_CYCLES(INIT)) DUT (
    .clk(clk), .rst(rst), .led_colour_select(led), .host_irq(irq),
    .control_port_clock_in(scl), .control_port_clock(scl_pin), .control_port_data_in(sda),
    .control_port_data(sda_pin), .comparator_result_in(cmp_in), .ramp_charge_out(ramp));
  i2c_host_model host (.clk(clk), .dev_scl(scl_pin), .dev_sda(sda_pin), .scl(scl), .sda(sda));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic i2c_wr(input logic [2:0] ptr, input logic [7:0] d);
    logic [7:0] rx;
    logic       ack;
    host.start();
    host.xfer({ADDR, 1'b0}, 1'b0, rx, ack);
    check({7'h00, ack}, 8'h00);
    host.xfer({5'h00, ptr}, 1'b0, rx, ack);
    check({7'h00, ack}, 8'h00);
    host.xfer(d, 1'b0, rx, ack);
    host.stop();
    check({7'h00, ack}, 8'h00);
  endtask : i2c_wr

  // pointer write, then a fresh start for the read; one byte then nack
  task automatic i2c_rd(input logic [2:0] ptr, output logic [7:0] d);
    logic ack;
    host.start();
    host.xfer({ADDR, 1'b0}, 1'b0, d, ack);
    host.xfer({5'h00, ptr}, 1'b0, d, ack);
    host.stop();
    host.start();
    host.xfer({ADDR, 1'b1}, 1'b0, d, ack);
    check({7'h00, ack}, 8'h00);
    host.xfer(8'hFF, 1'b0, d, ack);
    host.stop();
  endtask : i2c_rd

  task automatic t_reset();
    rst = 1'b1;
    cyc(4);
    check({6'h00, led}, 8'h00);
    check({7'h00, irq.oe}, 8'h00);
    check({7'h00, ramp}, 8'h00);
    rst = 1'b0;
  endtask : t_reset

  // busy shown from release, leds dark until the pin drops
  task automatic t_init();
    int n = 0;
    cyc(2);
    check({6'h00, irq}, 8'h03);
    while (irq.out === 1'b1 && n < 100) begin
      check({6'h00, led}, 8'h00);
      cyc(1);
      n++;
    end
    check({6'h00, irq}, 8'h01);
    check(8'(n >= INIT - 3 && n <= INIT + 2), 8'h01);
  endtask : t_init

  task automatic t_nack_status();
    logic [7:0] d;
    logic       ack;
    host.start();
    host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b0, d, ack);
    host.stop();
    check({7'h00, ack}, 8'h01);
    // target never stretches the clock, so its clock pin stays released
    check({6'h00, scl_pin}, 8'h00);
    i2c_rd(3'h5, d);
    check({7'h00, d[0]}, 8'h01);
  endtask : t_nack_status

  // shortest durations so the colour walk fits; order wraps blue to red
  task automatic t_leds();
    logic [1:0] want = 2'h1;
    int         n;
    for (int i = 1; i < 4; i++)
      i2c_wr(3'(i), 8'h01);
    i2c_wr(3'h0, 8'h01);
    repeat (4) begin
      n = 0;
      while (led !== want && n < 600) begin
        cyc(1);
        n++;
      end
      check({6'h00, led}, {6'h00, want});
      want = (want == 2'h3) ? 2'h1 : want + 2'h1;
    end
    i2c_wr(3'h0, 8'h00);
    cyc(2);
    check({6'h00, led}, 8'h00);
  endtask : t_leds

  // comparator held high keeps every trial bit, held low keeps none
  task automatic t_temp();
    logic [7:0] d;
    int         highs = 0;
    repeat (18000) begin
      cyc(1);
      highs += ramp;
    end
    check(8'(highs > 0), 8'h01);
    i2c_wr(3'h4, 8'h55);
    i2c_rd(3'h4, d);
    check(d, 8'hFF);
    cmp_in = 1'b0;
    cyc(18000);
    i2c_rd(3'h4, d);
    check(d, 8'h00);
  endtask : t_temp

  initial begin
    t_reset();
    t_init();
    t_nack_status();
    t_leds();
    t_temp();
    i2c_wr(3'h0, 8'h01);
    cyc(300);
    t_reset();
    t_init();
    tally_and_finish();
  end

  // run needs roughly 45000 cycles
  initial begin
    repeat (70000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_top
